// file: output_mux_pkg.sv
/*
  Constants for the parameter-driven digital output selector.
  Assumes a fieldbus front end presenting 16-bit holding-register accesses.
*/
package output_mux_pkg;
  // Holding address and layout of the output-setting word
  localparam logic [15:0] setting_addr = 16'h050c;
  localparam logic [15:0] setting_reset = 16'h0000;
  localparam logic [15:0] setting_max = 16'h00ff;
  // Selector base addresses for the four output function selectors
  localparam logic [15:0] select_addr_base = 16'h0224;
  // Function codes for setting-word bits and the reserved block, plus selector reset code and sizes
  localparam logic [7:0] code_param_bit0 = 8'h30;
  localparam logic [7:0] code_param_bit3 = 8'h33;
  localparam logic [7:0] code_reserved_lo = 8'h34;
  localparam logic [7:0] code_reserved_hi = 8'h3f;
  localparam logic [7:0] select_reset = 8'h00;
  localparam int num_outputs = 4;
  localparam int num_sources = 64;
endpackage : output_mux_pkg

// file: parameter_driven_output_mux.sv
/*
  Output selector: each of four digital outputs follows the source chosen
  by its function selector; codes 0x30..0x33 pick bits of the setting word.
  Assumes the fieldbus decoder gives one-cycle write strobes with address
  and data, and that other output functions arrive as same-clock levels.
*/
// Functional notes
// - Selector codes 0x30..0x33 drive the output from setting-word bits 0..3.
// - A setting-word bit drives every output whose selector chooses it.
// - Outputs with other functions keep following their own sources; reserved codes 0x34..0x3F hold them low.
// - Setting word is 16-bit RW, resets to zero, max 0xFF, at 0x50C.
// - Four function selectors exist, one per digital output.
`timescale 1ns/1ps
module parameter_driven_output_mux #(
  parameter int n_out = output_mux_pkg::num_outputs
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fieldbus holding-register access
  input wire logic bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_err,
  // Signal sources indexed by function code
  input wire logic [output_mux_pkg::num_sources-1:0] func_sources,
  // Digital outputs to the loads
  output logic [n_out-1:0] digital_out
);

  logic [15:0] setting_r;
  logic [15:0] setting_nxt;
  logic [7:0] select_r [n_out];
  logic [7:0] select_nxt [n_out];
  logic [n_out-1:0] out_r;
  logic [n_out-1:0] out_nxt;

  // Selector index for an address, or n_out when none matches
  function automatic int sel_index(input logic [15:0] a);
    sel_index = n_out;
    for (int i = 0; i < n_out; i++) begin
      if (a == output_mux_pkg::select_addr_base + 16'(2 * i)) begin
        sel_index = i;
      end
    end
  endfunction : sel_index

  // True when a selector code picks one of the setting-word bits
  function automatic logic is_bit_code(input logic [7:0] code);
    is_bit_code = code >= output_mux_pkg::code_param_bit0 &&
                  code <= output_mux_pkg::code_param_bit3;
  endfunction : is_bit_code

  // True when a selector code falls in the reserved block
  function automatic logic is_resv_code(input logic [7:0] code);
    is_resv_code = code >= output_mux_pkg::code_reserved_lo &&
                   code <= output_mux_pkg::code_reserved_hi;
  endfunction : is_resv_code

  // Route one selector code to its source level
  function automatic logic route(input logic [7:0] code,
                                 input logic [15:0] word,
                                 input logic [63:0] src);
    if (is_bit_code(code)) begin
      route = word[code[1:0]];
    end else if (is_resv_code(code)) begin
      route = 1'b0;
    end else begin
      route = src[code[5:0]];
    end
  endfunction : route

  // Next register values from bus writes
  always_comb begin
    int idx;
    idx = sel_index(bus_addr);
    setting_nxt = setting_r;
    select_nxt = select_r;
    if (bus_wr && bus_addr == output_mux_pkg::setting_addr) begin
      if (bus_wdata <= output_mux_pkg::setting_max) begin
        setting_nxt = bus_wdata;
      end
    end
    if (bus_wr && idx < n_out) begin
      select_nxt[idx] = bus_wdata[7:0];
    end
  end

  // Output mux: every output decoded from its own selector
  always_comb begin
    for (int i = 0; i < n_out; i++) begin
      out_nxt[i] = route(select_r[i], setting_r, 64'(func_sources));
    end
  end

  // Register the setting word and the selectors
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      setting_r <= output_mux_pkg::setting_reset;
      for (int i = 0; i < n_out; i++) begin
        select_r[i] <= output_mux_pkg::select_reset;
      end
    end else begin
      setting_r <= setting_nxt;
      select_r <= select_nxt;
    end
  end

  // Register the outputs so the loads see glitch-free levels
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign digital_out = out_r;

  // Read path and unmapped-address flag
  always_comb begin
    int idx;
    idx = sel_index(bus_addr);
    bus_rdata = 16'h0000;
    bus_err = 1'b0;
    if (bus_addr == output_mux_pkg::setting_addr) begin
      bus_rdata = setting_r;
    end else if (idx < n_out) begin
      bus_rdata = {8'h00, select_r[idx]};
    end else begin
      bus_err = 1'b1;
    end
  end

  // Setting-word write inside the limit, and one beyond it
  sequence s_word_ok;
    bus_wr && bus_addr == output_mux_pkg::setting_addr &&
      bus_wdata <= output_mux_pkg::setting_max;
  endsequence

  sequence s_word_over;
    bus_wr && bus_addr == output_mux_pkg::setting_addr &&
      bus_wdata > output_mux_pkg::setting_max;
  endsequence

  // Output 0 follows its setting bit one edge after the decode
  a_bit_route: assert property (@(posedge clk)
    disable iff (!reset_n)
    is_bit_code(select_r[0]) |=>
      digital_out[0] == $past(setting_r[select_r[0][1:0]]))
    else $error("output 0 not following setting bit");

  // Two outputs sharing one bit function move together
  a_shared_bit: assert property (@(posedge clk)
    disable iff (!reset_n)
    (select_r[0] == select_r[1] && is_bit_code(select_r[0])) |=>
      digital_out[0] == digital_out[1])
    else $error("shared function drives outputs apart");

  // Output 0 with a low code follows its own source
  a_other_source: assert property (@(posedge clk)
    disable iff (!reset_n)
    (select_r[0] < output_mux_pkg::code_param_bit0) |=>
      digital_out[0] == $past(func_sources[select_r[0][5:0]]))
    else $error("output 0 not following its source");

  // Accepted writes land, refused ones and idle cycles leave the word
  a_word_write: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_word_ok |=> setting_r == $past(bus_wdata))
    else $error("setting word write lost");
  a_word_over: assert property (@(posedge clk)
    disable iff (!reset_n)
    s_word_over |=> $stable(setting_r))
    else $error("over-range setting write taken");
  a_word_hold: assert property (@(posedge clk)
    disable iff (!reset_n)
    !bus_wr |=> $stable(setting_r))
    else $error("setting word changed without a write");
  a_word_limit: assert property (@(posedge clk)
    disable iff (!reset_n)
    setting_r <= output_mux_pkg::setting_max)
    else $error("setting word above limit");

  // Reset clears the word, the first selector and all outputs
  a_reset_zero: assert property (@(posedge clk)
    !reset_n |=> setting_r == output_mux_pkg::setting_reset &&
      select_r[0] == output_mux_pkg::select_reset && digital_out == '0)
    else $error("reset values wrong");

  // Read data and error flag for the setting word
  a_read_word: assert property (@(posedge clk)
    disable iff (!reset_n)
    (bus_addr == output_mux_pkg::setting_addr) |->
      (bus_rdata == setting_r && !bus_err))
    else $error("setting word read wrong");

  // Unmapped addresses read as zero and raise the error flag
  a_unmapped_err: assert property (@(posedge clk)
    disable iff (!reset_n)
    (bus_addr != output_mux_pkg::setting_addr &&
     sel_index(bus_addr) == n_out) |->
      (bus_err && bus_rdata == 16'h0000))
    else $error("unmapped access not flagged");

  // Selector 1 write lands in its own register
  a_sel_write: assert property (@(posedge clk)
    disable iff (!reset_n)
    (bus_wr && bus_addr == output_mux_pkg::select_addr_base + 16'h0002) |=>
      select_r[1] == $past(bus_wdata[7:0]))
    else $error("selector 1 write lost");

  // A reserved code held for two edges keeps output 2 low
  a_reserved_off: assert property (@(posedge clk)
    disable iff (!reset_n)
    is_resv_code(select_r[2]) [*2] |-> !digital_out[2])
    else $error("reserved code drives output");

  // Per-output checks of every selector class and the read-back
  for (genvar g = 0; g < n_out; g++) begin : g_out_chk
    a_bit_each: assert property (@(posedge clk)
      disable iff (!reset_n)
      is_bit_code(select_r[g]) |=>
        digital_out[g] == $past(setting_r[select_r[g][1:0]]))
      else $error("output not following its setting bit");
    a_resv_each: assert property (@(posedge clk)
      disable iff (!reset_n)
      is_resv_code(select_r[g]) |=> !digital_out[g])
      else $error("reserved code drives an output");
    a_src_each: assert property (@(posedge clk)
      disable iff (!reset_n)
      (!is_bit_code(select_r[g]) && !is_resv_code(select_r[g])) |=>
        digital_out[g] == $past(func_sources[select_r[g][5:0]]))
      else $error("output not following its own source");
    a_write_reach: assert property (@(posedge clk)
      disable iff (!reset_n)
      s_word_ok ##1 (!bus_wr && is_bit_code(select_r[g])) |=>
        digital_out[g] == setting_r[select_r[g][1:0]])
      else $error("setting write did not reach the output");
    a_sel_hold: assert property (@(posedge clk)
      disable iff (!reset_n)
      !bus_wr |=> select_r[g] == $past(select_r[g]))
      else $error("selector changed without a write");
    a_read_sel: assert property (@(posedge clk)
      disable iff (!reset_n)
      (bus_addr == output_mux_pkg::select_addr_base + 16'(2 * g)) |->
        (bus_rdata == {8'h00, select_r[g]} && !bus_err))
      else $error("selector read wrong");
  end

endmodule : parameter_driven_output_mux

// file: load_model.sv
/* External loads on the four digital outputs.
   Assumes active-high outputs driven by the selector. */
`timescale 1ns/1ps
module load_model (
  // Outputs from the drive
  input wire logic [3:0] drive_in,
  // Load state seen by the bench
  output logic [3:0] energised
);
  // A load is energised while its output is high
  assign energised = drive_in;
endmodule : load_model

// file: tb.sv
/* Self-checking bench for the output selector.
   Assumes the output_mux_pkg constants and a 10 MHz clock. */
`timescale 1ns/1ps
module tb;
  logic clk = 0, reset_n = 0, bus_wr = 0, bus_err;
  logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, word;
  logic [63:0] func_sources = 64'h0;
  logic [3:0] digital_out, energised, exp_out;
  logic [7:0] sel [4];
  int num_errors = 0, total_checks = 0, seed = 5968;
  parameter_driven_output_mux uut (.clk(clk), .reset_n(reset_n),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_err(bus_err),
    .func_sources(func_sources), .digital_out(digital_out));
  load_model loads (.drive_in(digital_out), .energised(energised));
  // Clock and watchdog
  initial forever #50 clk = ~clk;
  initial begin
    #5000000;
    num_errors++;
    complete_run();
  end
  // Expected level of one output
  function automatic logic route(logic [7:0] c, logic [15:0] w);
    if (c >= 8'h30 && c <= 8'h33) return w[c[1:0]];
    if (c >= 8'h34 && c <= 8'h3f) return 1'b0;
    return func_sources[c[5:0]];
  endfunction : route
  task automatic compare(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  // One write, then one idle cycle
  task automatic write(logic [15:0] a, logic [15:0] d);
    bus_wr = 1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    bus_wr = 0;
    @(negedge clk);
  endtask : write
  // Read one register between edges, then realign to the falling edge
  task automatic check_reg(logic [15:0] a, logic [15:0] e);
    bus_addr = a;
    #10;
    compare(bus_rdata, e);
    @(negedge clk);
  endtask : check_reg
  // Output levels against what the rules expect
  task automatic compare_out(logic [3:0] got, logic [3:0] exp);
    compare({12'h0, got}, {12'h0, exp});
  endtask : compare_out
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1;
    check_reg(output_mux_pkg::setting_addr, 16'h0000);
    compare({15'h0, bus_err}, 16'h0000);
    for (int i = 0; i < 4; i++) check_reg(16'h0224 + 16'(2 * i), 16'h0);
    check_reg(16'h0100, 16'h0000);
    compare({15'h0, bus_err}, 16'h0001);
    write(output_mux_pkg::setting_addr, 16'h00ff);
    write(output_mux_pkg::setting_addr, 16'h0100);
    check_reg(output_mux_pkg::setting_addr, 16'h00ff);
    for (int i = 0; i < 4; i++) write(16'h0224 + 16'(2 * i), 16'h0031);
    write(output_mux_pkg::setting_addr, 16'h0002);
    compare_out(energised, 4'hf);
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 4; i++) begin
        sel[i] = 8'($random(seed));
        if (k % 2 == 0) sel[i] = sel[i] & 8'h3f;
        if (k == 0) sel[i] = 8'h30 + 8'(i);
        if (k == 1) sel[i] = 8'h34 + 8'(i * 4);
        write(16'h0224 + 16'(2 * i), {8'h00, sel[i]});
        check_reg(16'h0224 + 16'(2 * i), {8'h00, sel[i]});
      end
      word = 16'($random(seed)) & 16'h00ff;
      func_sources = {$random(seed), $random(seed)};
      write(output_mux_pkg::setting_addr, word);
      for (int i = 0; i < 4; i++) exp_out[i] = route(sel[i], word);
      compare_out(digital_out, exp_out);
      check_reg(output_mux_pkg::setting_addr, word);
    end
    // Second reset in mid-run clears the word, selectors and outputs
    reset_n = 0;
    repeat (2) @(negedge clk);
    reset_n = 1;
    compare_out(digital_out, 4'h0);
    check_reg(output_mux_pkg::setting_addr, 16'h0000);
    for (int i = 0; i < 4; i++) check_reg(16'h0224 + 16'(2 * i), 16'h0);
    compare_out(digital_out, {4{func_sources[0]}});
    complete_run();
  end
endmodule : tb
